// ---- pwm_cfg.svh ----
// offsets, field positions, reset values and sizes of the four channel pwm block
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH
// ======================================================================
// global register offsets (byte addresses)
`define PWM_OFF_MODE 12'h000
`define PWM_OFF_ENA 12'h004
`define PWM_OFF_DIS 12'h008
`define PWM_OFF_SR 12'h00c
`define PWM_OFF_IER 12'h010
`define PWM_OFF_IDR 12'h014
`define PWM_OFF_IMR 12'h018
`define PWM_OFF_ISR 12'h01c
// ======================================================================
// channel register offsets
`define PWM_CH_BASE 12'h200
`define PWM_CH_STRIDE 12'h020
`define PWM_CH_CMR 12'h000
`define PWM_CH_DUTY_VALUE 12'h004
`define PWM_CH_PERIOD_VALUE 12'h008
`define PWM_CH_CCNT 12'h00c
`define PWM_CH_CUPD 12'h010
// ======================================================================
// mode register fields
`define PWM_DIV_FACTOR_A_MSB 7
`define PWM_DIV_FACTOR_A_LSB 0
`define PWM_PRESCALE_SEL_A_MSB 11
`define PWM_PRESCALE_SEL_A_LSB 8
`define PWM_DIV_FACTOR_B_MSB 23
`define PWM_DIV_FACTOR_B_LSB 16
`define PWM_PRESCALE_SEL_B_MSB 27
`define PWM_PRESCALE_SEL_B_LSB 24
`define PWM_MODE_MASK 32'h0fff0fff
`define PWM_MODE_RST 32'h00000000
// ======================================================================
// channel mode register fields
`define PWM_CMR_CSEL_MSB 3
`define PWM_CMR_CSEL_LSB 0
`define PWM_CMR_ALIGN 8
`define PWM_CMR_POL 9
`define PWM_CMR_UPD 10
// ======================================================================
// clock generator sizes
`define PWM_PRE_BITS 10
`define PWM_PRE_OUTS 11
`define PWM_CLK_OUTS 13
`define PWM_SEL_OFF 4'hd
`endif

// ---- pwm_pkg.sv ----
// shared types of the four channel pwm block
package pwm_pkg;
  // counter direction, gray ordered along up then down
  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } cnt_dir_t;
  // ahb transfer kinds
  typedef enum logic [1:0] {
    TR_IDLE = 2'h0,
    TR_BUSY = 2'h1,
    TR_NONSEQ = 2'h2,
    TR_SEQ = 2'h3
  } htrans_t;
endpackage : pwm_pkg

// ---- pwm_four_channel.sv ----
// four channel pwm generator with clock generator and ahb-lite register slave
// ======================================================================
`timescale 1ns/1ps
`include "pwm_cfg.svh"

module pwm_four_channel
  import pwm_pkg::*;
#(
  parameter int NCH = 4,
  parameter int CW = 16
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // master clock enable from the power manager
  input wire logic clk_en_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // channel waveforms and interrupt
  output logic [NCH-1:0] channel_wave_out_o,
  output logic irq_o
);

  // ======================================================================
  // helper functions
  // picks one generator tick by select code, out of range gives none
  function automatic logic pick_tick(input logic [`PWM_CLK_OUTS-1:0] ticks, input logic [3:0] sel);
    pick_tick = (sel < `PWM_SEL_OFF) ? ticks[sel] : 1'b0;
  endfunction : pick_tick

  // address of one register of one channel
  function automatic logic [11:0] ch_addr(input int ch, input logic [11:0] off);
    ch_addr = `PWM_CH_BASE + 12'(ch) * `PWM_CH_STRIDE + off;
  endfunction : ch_addr

  // ======================================================================
  // bus address phase capture
  logic wr_ff;
  logic rd_ff;
  logic [11:0] addr_ff;
  logic [31:0] mode_ff;
  logic [NCH-1:0] ena_ff;
  logic [NCH-1:0] imr_ff;
  logic [NCH-1:0] isr_ff;
  logic [NCH-1:0] period_end;
  logic [11:0] wr_addr;
  logic wr_go;
  logic rd_go;
  logic [31:0] rdata;

  // a transfer is taken when selected, nonseq or seq and the bus is ready
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      addr_ff <= 12'h000;
    end else if (hready_i) begin
      wr_ff <= hsel_i && htrans_i[1] && hwrite_i;
      rd_ff <= hsel_i && htrans_i[1] && !hwrite_i;
      addr_ff <= {haddr_i[11:2], 2'b00};
    end
  end

  // zero wait states, always okay; data phase acts on the registered address
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign wr_addr = addr_ff;
  assign wr_go = wr_ff && hready_i;
  assign rd_go = rd_ff && hready_i;

  // ======================================================================
  // mode register: divider factors and prescale selects
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      mode_ff <= `PWM_MODE_RST;
    end else if (wr_go && wr_addr == `PWM_OFF_MODE) begin
      mode_ff <= hwdata_i & `PWM_MODE_MASK;
    end
  end

  // ======================================================================
  // clock generator: modulo counter prescaler
  logic [`PWM_PRE_BITS-1:0] pre_cnt_ff;
  logic [`PWM_PRE_OUTS-1:0] pre_tick;
  logic [1:0] div_tick;
  logic [`PWM_CLK_OUTS-1:0] gen_tick;

  // prescaler advances only while the master clock is enabled
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pre_cnt_ff <= '0;
    end else if (clk_en_i) begin
      pre_cnt_ff <= pre_cnt_ff + 1'b1;
    end
  end

  // undivided tick follows the enable; the others need reset released too
  assign pre_tick[0] = clk_en_i;
  for (genvar k = 1; k < `PWM_PRE_OUTS; k++) begin : g_pre
    assign pre_tick[k] = clk_en_i && rstn_i && (&pre_cnt_ff[k-1:0]);
  end

  // ======================================================================
  // clock generator: two linear dividers
  for (genvar d = 0; d < 2; d++) begin : g_div
    logic [7:0] dcnt_ff;
    logic [7:0] factor;
    logic [3:0] sel;
    logic src;
    assign factor = (d == 0) ? mode_ff[`PWM_DIV_FACTOR_A_MSB:`PWM_DIV_FACTOR_A_LSB] : mode_ff[`PWM_DIV_FACTOR_B_MSB:`PWM_DIV_FACTOR_B_LSB];
    assign sel = (d == 0) ? mode_ff[`PWM_PRESCALE_SEL_A_MSB:`PWM_PRESCALE_SEL_A_LSB] : mode_ff[`PWM_PRESCALE_SEL_B_MSB:`PWM_PRESCALE_SEL_B_LSB];
    assign src = pick_tick({2'b00, pre_tick}, sel);
    // a zero factor stops the output, one passes the source through
    assign div_tick[d] = (factor != 8'h00) && src && ({1'b0, dcnt_ff} + 9'h001 >= {1'b0, factor});

    // counts source ticks and wraps after factor of them
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i || factor == 8'h00) begin
        dcnt_ff <= 8'h00;
      end else if (div_tick[d]) begin
        dcnt_ff <= 8'h00;
      end else if (src) begin
        dcnt_ff <= dcnt_ff + 8'h01;
      end
    end
  end

  // thirteen clocks offered to each channel
  assign gen_tick = {div_tick, pre_tick};

  // ======================================================================
  // channel register storage
  logic [3:0] csel_ff [NCH];
  logic [NCH-1:0] align_ff;
  logic [NCH-1:0] pol_ff;
  logic [NCH-1:0] upd_sel_ff;
  logic [CW-1:0] prd_ff [NCH];
  logic [CW-1:0] dty_ff [NCH];
  logic [CW-1:0] cnt_ff [NCH];
  logic [CW-1:0] upd_ff [NCH];
  logic [NCH-1:0] upd_pend_ff;
  logic [NCH-1:0] wave_ff;
  cnt_dir_t dir_ff [NCH];

  // ======================================================================
  // channel enable and disable
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ena_ff <= '0;
    end else if (wr_go && wr_addr == `PWM_OFF_ENA) begin
      ena_ff <= ena_ff | hwdata_i[NCH-1:0];
    end else if (wr_go && wr_addr == `PWM_OFF_DIS) begin
      ena_ff <= ena_ff & ~hwdata_i[NCH-1:0];
    end
  end

  // ======================================================================
  // per channel counter, comparator and buffers
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic ctick;
    logic start_now;
    logic wrap_up;
    logic [CW:0] cnt_inc;
    assign ctick = ena_ff[c] && pick_tick(gen_tick, csel_ff[c]);
    assign start_now = wr_go && wr_addr == `PWM_OFF_ENA && hwdata_i[c] && !ena_ff[c];
    assign cnt_inc = {1'b0, cnt_ff[c]} + {{CW{1'b0}}, 1'b1};
    assign wrap_up = cnt_inc >= {1'b0, prd_ff[c]};
    // left: one period is prd ticks; center: up prd then down prd
    assign period_end[c] = ctick && ((align_ff[c] == 1'b0 || prd_ff[c] == '0) ? wrap_up :
                           (dir_ff[c] == DIR_DOWN && cnt_ff[c] == {{(CW-1){1'b0}}, 1'b1}));

    // mode fields; polarity and alignment only change while disabled
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
        csel_ff[c] <= 4'h0;
        align_ff[c] <= 1'b0;
        pol_ff[c] <= 1'b0;
        upd_sel_ff[c] <= 1'b0;
      end else if (wr_go && wr_addr == ch_addr(c, `PWM_CH_CMR)) begin
        csel_ff[c] <= hwdata_i[`PWM_CMR_CSEL_MSB:`PWM_CMR_CSEL_LSB];
        upd_sel_ff[c] <= hwdata_i[`PWM_CMR_UPD];
        if (!ena_ff[c]) begin
          align_ff[c] <= hwdata_i[`PWM_CMR_ALIGN];
          pol_ff[c] <= hwdata_i[`PWM_CMR_POL];
        end
      end
    end

    // period and duty: direct writes while disabled, buffered update at period end
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
        prd_ff[c] <= '0;
        dty_ff[c] <= '0;
        upd_ff[c] <= '0;
        upd_pend_ff[c] <= 1'b0;
      end else begin
        if (wr_go && !ena_ff[c] && wr_addr == ch_addr(c, `PWM_CH_PERIOD_VALUE)) begin
          prd_ff[c] <= hwdata_i[CW-1:0];
        end else if (wr_go && !ena_ff[c] && wr_addr == ch_addr(c, `PWM_CH_DUTY_VALUE)) begin
          dty_ff[c] <= hwdata_i[CW-1:0];
        end else if (period_end[c] && upd_pend_ff[c]) begin
          if (upd_sel_ff[c]) begin
            prd_ff[c] <= upd_ff[c];
          end else begin
            dty_ff[c] <= upd_ff[c];
          end
        end
        // a new update write wins over the pending one being consumed
        if (wr_go && wr_addr == ch_addr(c, `PWM_CH_CUPD)) begin
          upd_ff[c] <= hwdata_i[CW-1:0];
          upd_pend_ff[c] <= 1'b1;
        end else if (period_end[c]) begin
          upd_pend_ff[c] <= 1'b0;
        end
      end
    end

    // counter: restarts at zero on enable, holds while its clock is gated
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i || start_now || !ena_ff[c]) begin
        cnt_ff[c] <= '0;
        dir_ff[c] <= DIR_UP;
      end else if (ctick) begin
        if (align_ff[c] == 1'b0 || prd_ff[c] == '0) begin
          cnt_ff[c] <= wrap_up ? '0 : cnt_inc[CW-1:0];
          dir_ff[c] <= DIR_UP;
        end else if (dir_ff[c] == DIR_UP) begin
          cnt_ff[c] <= cnt_inc[CW-1:0];
          if (wrap_up) begin
            dir_ff[c] <= DIR_DOWN;
          end
        end else begin
          cnt_ff[c] <= cnt_ff[c] - {{(CW-1){1'b0}}, 1'b1};
          if (period_end[c]) begin
            dir_ff[c] <= DIR_UP;
          end
        end
      end
    end

    // output: polarity level for duty ticks, inverse for the rest
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
        wave_ff[c] <= 1'b0;
      end else if (!ena_ff[c] || start_now) begin
        wave_ff[c] <= pol_ff[c];
      end else if (clk_en_i) begin
        // duty at period is fixed start level, zero duty fixed inverse
        wave_ff[c] <= (dty_ff[c] >= prd_ff[c] || cnt_ff[c] < dty_ff[c]) ? pol_ff[c] : !pol_ff[c];
      end
    end
  end

  assign channel_wave_out_o = wave_ff;

  // ======================================================================
  // interrupt mask and period end status
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      imr_ff <= '0;
    end else if (wr_go && wr_addr == `PWM_OFF_IER) begin
      imr_ff <= imr_ff | hwdata_i[NCH-1:0];
    end else if (wr_go && wr_addr == `PWM_OFF_IDR) begin
      imr_ff <= imr_ff & ~hwdata_i[NCH-1:0];
    end
  end

  // status clears on read; a period end in the same cycle stays set
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      isr_ff <= '0;
    end else if (rd_go && addr_ff == `PWM_OFF_ISR) begin
      isr_ff <= period_end;
    end else begin
      isr_ff <= isr_ff | period_end;
    end
  end

  // level interrupt for a level sensitive consumer
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(isr_ff & imr_ff);
    end
  end

  // ======================================================================
  // read data mux, unmapped and write-only addresses read zero
  always_comb begin
    rdata = 32'h00000000;
    case (addr_ff)
      `PWM_OFF_MODE: rdata = mode_ff;
      `PWM_OFF_SR: rdata[NCH-1:0] = ena_ff;
      `PWM_OFF_IMR: rdata[NCH-1:0] = imr_ff;
      `PWM_OFF_ISR: rdata[NCH-1:0] = isr_ff;
      default: begin
        for (int c = 0; c < NCH; c++) begin
          if (addr_ff == ch_addr(c, `PWM_CH_CMR)) begin
            rdata[`PWM_CMR_CSEL_MSB:`PWM_CMR_CSEL_LSB] = csel_ff[c];
            rdata[`PWM_CMR_ALIGN] = align_ff[c];
            rdata[`PWM_CMR_POL] = pol_ff[c];
            rdata[`PWM_CMR_UPD] = upd_sel_ff[c];
          end else if (addr_ff == ch_addr(c, `PWM_CH_DUTY_VALUE)) begin
            rdata[CW-1:0] = dty_ff[c];
          end else if (addr_ff == ch_addr(c, `PWM_CH_PERIOD_VALUE)) begin
            rdata[CW-1:0] = prd_ff[c];
          end else if (addr_ff == ch_addr(c, `PWM_CH_CCNT)) begin
            rdata[CW-1:0] = cnt_ff[c];
          end
        end
      end
    endcase
  end

  // read data is only driven during a read data phase
  assign hrdata_o = rd_ff ? rdata : 32'h00000000;

endmodule : pwm_four_channel

// ---- pwm_four_channel_props.sv ----
// assertion checker of the four channel pwm block, bound to its top module
`timescale 1ns/1ps
module pwm_four_channel_props
  import pwm_pkg::*;
#(
  parameter int NCH = 4,
  parameter int CW = 16
) (
  // clock, reset and gating
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // ahb-lite slave side
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // waveforms and interrupt
  input wire logic [NCH-1:0] channel_wave_out_o,
  input wire logic irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // ======================================================================
  // address phases of one offset
  sequence s_rd(logic [11:0] a);
    hsel_i && htrans_i[1] && hready_i && !hwrite_i && haddr_i[11:0] == a;
  endsequence
  sequence s_wr(logic [11:0] a);
    hsel_i && htrans_i[1] && hready_i && hwrite_i && haddr_i[11:0] == a;
  endsequence
  // ======================================================================
  // bus answers, release state, freezing and masking
  property p_ready; hreadyout_o; endproperty
  property p_okay; !hresp_o; endproperty
  property p_release; $rose(rstn_i) |-> channel_wave_out_o == '0 && !irq_o; endproperty
  property p_rdata_idle; !(hsel_i && htrans_i[1] && hready_i && !hwrite_i) |=> hrdata_o == 32'h0; endproperty
  property p_unmapped; s_rd(12'h100) |=> hrdata_o == 32'h0; endproperty
  property p_status; s_rd(12'h00c) |=> hrdata_o[31:4] == 28'h0; endproperty
  property p_freeze; !clk_en_i && $past(!clk_en_i) |-> $stable(channel_wave_out_o); endproperty
  property p_irq_off; s_wr(12'h014) ##1 hwdata_i[3:0] == 4'hf |-> ##2 !irq_o; endproperty
  a_ready: assert property (p_ready) else $error("ready dropped");
  a_okay: assert property (p_okay) else $error("error response");
  a_release: assert property (p_release) else $error("outputs not idle after reset");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside data phase");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_status: assert property (p_status) else $error("status beyond four channels");
  a_freeze: assert property (p_freeze) else $error("waveform moved while gated");
  a_irq_off: assert property (p_irq_off) else $error("interrupt kept after full disable");
endmodule : pwm_four_channel_props
bind pwm_four_channel pwm_four_channel_props #(.NCH(NCH), .CW(CW)) u_props (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .channel_wave_out_o(channel_wave_out_o), .irq_o(irq_o)
);

// ---- pwm_load_model.sv ----
// load model on the waveform pins, counting high cycles and rising edges in a window
`timescale 1ns/1ps
module pwm_load_model (
  // clock and measurement window
  input wire logic core_clk_i,
  input wire logic meas_i,
  // waveforms seen at the pins
  input wire logic [3:0] wave_i,
  // counts of the last window
  output logic [15:0] high_cnt_o [4],
  output logic [15:0] rise_cnt_o [4]
);
  logic [3:0] prev_ff;
  logic meas_ff;
  // ======================================================================
  // counts restart on the first cycle of each window
  always_ff @(posedge core_clk_i) begin
    prev_ff <= wave_i;
    meas_ff <= meas_i;
    for (int i = 0; i < 4; i++) begin
      if (meas_i) begin
        high_cnt_o[i] <= (meas_ff ? high_cnt_o[i] : 16'h0) + {15'h0, wave_i[i]};
        rise_cnt_o[i] <= (meas_ff ? rise_cnt_o[i] : 16'h0) + {15'h0, wave_i[i] & ~prev_ff[i]};
      end
    end
  end
endmodule : pwm_load_model

// ---- test_four_channel_pwm_with_clock_divider.sv ----
// self-checking testbench of the four channel pwm block
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module test_four_channel_pwm_with_clock_divider;
  import pwm_pkg::*;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = TR_IDLE;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o, rd_q, rv;
  logic hreadyout_o, hresp_o, irq_o;
  logic meas = 1'b0;
  logic [3:0] channel_wave_out_o;
  logic [15:0] high_cnt [4];
  logic [15:0] rise_cnt [4];
  logic [15:0] rnd = 16'h0024;
  logic [15:0] prd, dty;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  // ======================================================================
  // design, load model, clock and read capture
  pwm_four_channel dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .channel_wave_out_o(channel_wave_out_o), .irq_o(irq_o));
  pwm_load_model u_load (.core_clk_i(core_clk_i), .meas_i(meas), .wave_i(channel_wave_out_o),
    .high_cnt_o(high_cnt), .rise_cnt_o(rise_cnt));
  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) rd_q <= hrdata_o;
  // ======================================================================
  // helpers: random source, addresses, bus cycles, compares
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [11:0] ca(input int c, input logic [11:0] off);
    return `PWM_CH_BASE + 12'(c) * `PWM_CH_STRIDE + off;
  endfunction : ca
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic ahb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk_i);
    hsel_i <= 1'b1;
    haddr_i <= {20'h0, a};
    hwrite_i <= w;
    htrans_i <= TR_NONSEQ;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= TR_IDLE;
    hwdata_i <= d;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    #1;
    q = rd_q;
  endtask : ahb_xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb_xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    ahb_xfer(1'b0, a, 32'h0, q);
    check(name, exp, q);
  endtask : rd_chk
  task automatic measure(input int w);
    @(posedge core_clk_i);
    meas <= 1'b1;
    repeat (w) @(posedge core_clk_i);
    meas <= 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask : measure
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // ======================================================================
  // hang guard
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  // ======================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd_chk("mode", `PWM_OFF_MODE, 32'h0);
    rd_chk("chan mode", ca(0, `PWM_CH_CMR), 32'h0);
    rd_chk("status", `PWM_OFF_SR, 32'h0);
    wr(12'h100, 32'hffffffff);
    rd_chk("unmapped", 12'h100, 32'h0);
    // random divider settings, the last one written with the block clock gated
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      rv = {lfsr(rnd), rnd};
      @(posedge core_clk_i);
      clk_en_i <= (i != 3);
      wr(`PWM_OFF_MODE, rv);
      rd_chk("mode rw", `PWM_OFF_MODE, rv & `PWM_MODE_MASK);
    end
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    wr(`PWM_OFF_MODE, 32'h0);
    prd = 16'h8 + {12'h0, rnd[3:0]};
    dty = {14'h0, rnd[5:4]} + 16'h1;
    // ch0 left, ch1 center, ch2 duty zero, ch3 duty equal to period
    for (int c = 0; c < 4; c++) begin
      wr(ca(c, `PWM_CH_CMR), (c == 1) ? 32'h100 : 32'h0);
      wr(ca(c, `PWM_CH_DUTY_VALUE), (c == 2) ? 32'h0 : (c == 3) ? {16'h0, prd} : {16'h0, dty});
      wr(ca(c, `PWM_CH_PERIOD_VALUE), {16'h0, prd});
    end
    wr(`PWM_OFF_ENA, 32'hf);
    rd_chk("enabled", `PWM_OFF_SR, 32'hf);
    wr(ca(0, `PWM_CH_CMR), 32'h300);
    rd_chk("pol locked", ca(0, `PWM_CH_CMR), 32'h0);
    measure(6 * prd);
    check("left high", 6 * (prd - dty), high_cnt[0]);
    check("left rises", 6, rise_cnt[0]);
    check("center rises", 3, rise_cnt[1]);
    check("fixed high", 6 * prd, high_cnt[2]);
    check("fixed low", 0, high_cnt[3]);
    // buffered duty update, then buffered period update
    for (int u = 0; u < 2; u++) begin
      wr(ca(0, `PWM_CH_CMR), {21'h0, u[0], 10'h0});
      wr(ca(0, `PWM_CH_CUPD), {16'h0, (u == 1) ? prd + 16'h4 : dty + 16'h1});
      if (u == 1) prd = prd + 16'h4;
      else dty = dty + 16'h1;
      repeat (64) @(posedge core_clk_i);
      rd_chk("period reg", ca(0, `PWM_CH_PERIOD_VALUE), {16'h0, prd});
      measure(6 * prd);
      check("updated high", 6 * (prd - dty), high_cnt[0]);
    end
    // gate the block clock mid-run, counter holds and resumes
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    ahb_xfer(1'b0, ca(0, `PWM_CH_CCNT), 32'h0, rv);
    repeat (20) @(posedge core_clk_i);
    rd_chk("held count", ca(0, `PWM_CH_CCNT), rv);
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    measure(6 * prd);
    check("resumed high", 6 * (prd - dty), high_cnt[0]);
    // period end interrupt held as a level until the status read
    wr(`PWM_OFF_IER, 32'h1);
    repeat (2 * prd) @(posedge core_clk_i);
    wr(`PWM_OFF_DIS, 32'hf);
    repeat (20) @(posedge core_clk_i);
    #1;
    check("irq held", 1, irq_o);
    rd_chk("mask", `PWM_OFF_IMR, 32'h1);
    // status bits set on every channel's period end, masked or not
    rd_chk("isr", `PWM_OFF_ISR, 32'hf);
    repeat (3) @(posedge core_clk_i);
    #1;
    check("irq cleared", 0, irq_o);
    rd_chk("disabled", `PWM_OFF_SR, 32'h0);
    wr(ca(0, `PWM_CH_CMR), 32'h200);
    repeat (3) @(posedge core_clk_i);
    #1;
    check("idle level", 1, channel_wave_out_o[0]);
    wr(`PWM_OFF_IDR, 32'hf);
    rd_chk("mask off", `PWM_OFF_IMR, 32'h0);
    test_done();
  end
endmodule : test_four_channel_pwm_with_clock_divider
